// file: verilog/fdma_defines.vh
// fdma_defines.vh: constants for the four-channel dma controller
// assumes: included by bare name from the design files under verilog/
`ifndef FDMA_DEFINES_VH
`define FDMA_DEFINES_VH
// register map, 16-bit registers at plain offsets
`define FDMA_REG_CTRL0 8'h00
`define FDMA_REG_STAT 8'h20
`define FDMA_REG_LAST_LO 8'h21
`define FDMA_REG_LAST_HI 8'h22
// per channel block: base = 8'h00 + 8 * ch
`define FDMA_CH_STRIDE 8'h08
`define FDMA_OFS_CTRL 3'h0
`define FDMA_OFS_SEL 3'h1
`define FDMA_OFS_STA_LO 3'h2
`define FDMA_OFS_STB_LO 3'h3
`define FDMA_OFS_PAD 3'h4
`define FDMA_OFS_CNT 3'h5
`define FDMA_OFS_STA_HI 3'h6
`define FDMA_OFS_STB_HI 3'h7
// channel control fields
`define FDMA_CTL_EN 0
`define FDMA_CTL_SIZE 1
`define FDMA_CTL_DIR 2
`define FDMA_CTL_HALF 3
`define FDMA_CTL_AMODE_LO 4
`define FDMA_CTL_AMODE_HI 5
`define FDMA_CTL_MODE_LO 6
`define FDMA_CTL_MODE_HI 7
`define FDMA_CTL_FORCE 8
// address modes
`define FDMA_AM_INC 2'h0
`define FDMA_AM_FIX 2'h1
`define FDMA_AM_PERI 2'h2
// block modes: bit 0 auto-repeat, bit 1 ping-pong
`define FDMA_BM_REPEAT 0
`define FDMA_BM_PINGPONG 1
// request select codes
`define FDMA_SEL_EXT_INT_ZERO 8'h00
`define FDMA_SEL_CAPTURE_ONE 8'h01
`define FDMA_SEL_COMPARE_ONE 8'h02
`define FDMA_SEL_SECOND_TIMER 8'h07
`define FDMA_SEL_UART_ONE_RX 8'h0B
`define FDMA_SEL_UART_ONE_TX 8'h0C
// peripheral data addresses
`define FDMA_PA_CAPTURE_ONE_BUF 16'h0144
`define FDMA_PA_COMPARE_ONE_PRI 16'h0906
`define FDMA_PA_COMPARE_ONE_SEC 16'h0904
`define FDMA_PA_UART_ONE_RX 16'h0226
`define FDMA_PA_UART_ONE_TX 16'h0224
// reset values
`define FDMA_RST_LAST 24'h000000
`endif

// file: verilog/fdma_top.v
// fdma_top.v: four-channel dma controller, engine and register file
// assumes: one 10 MHz clock, peripherals and arbiter on the same clock
// Behaviour
// - four independent channels, each tied to a selected peripheral
// - each channel moves data one way only, set by its direction bit
// - fixed channel-number priority picks one; other requests stay pending
// - sram access goes through the shared arbiter; dma waits for grant
// - block done raises the channel's cpu interrupt pulse
// - interrupt optionally at half block instead of full block
// - sram address post-increments or stays fixed
// - peripheral-indirect mode takes the address from the peripheral
// - byte or 16-bit word transfer per channel
// - start on software force or on selected peripheral request
// - one-shot stops after a block; auto-repeat restarts it
// - ping-pong alternates between two sram start addresses per block
// - 8-bit select code chooses any of the request sources
// - external interrupt zero code 00h, second timer code 07h
// - uart one receiver code 0Bh, reads address 0226h
// - uart one transmitter code 0Ch, writes address 0224h
// - capture one code 01h, reads buffer at 0144h
// - compare one code 02h, writes 0906h or 0904h
// - last sram address readable as 24 bits, high upper byte zero
// - timer overflow and external interrupt events can trigger transfers
`include "fdma_defines.vh"
module fdma_top (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [255:0] irq_src,
    input wire [63:0] peri_addr_in,
    output reg sram_req,
    input wire sram_gnt,
    output reg sram_we,
    output reg [23:0] sram_addr,
    output reg [15:0] sram_wdata,
    output reg sram_byte,
    input wire [15:0] sram_rdata,
    output reg peri_req,
    input wire peri_ack,
    output reg peri_we,
    output reg [15:0] peri_addr,
    output reg [15:0] peri_wdata,
    output reg peri_byte,
    input wire [15:0] peri_rdata,
    output reg [3:0] ch_irq
);
localparam ST_IDLE = 2'h0;
localparam ST_SRC = 2'h1;
localparam ST_DST = 2'h2;
localparam ST_END = 2'h3;

reg [15:0] ctrl [0:3];
reg [7:0] sel [0:3];
reg [23:0] sta [0:3];
reg [23:0] stb [0:3];
reg [15:0] pad [0:3];
reg [15:0] cnt [0:3];
reg [15:0] done_cnt [0:3];
reg [23:0] cur [0:3];
reg [3:0] pp_b;
reg [3:0] pend;
reg [3:0] src_q;
reg [1:0] state;
reg [1:0] act;
reg [15:0] data_q;
reg [23:0] last_sram_address;
reg [1:0] pick;
reg pick_ok;
wire [3:0] src_now;
wire [3:0] rise;
wire [2:0] ch_sel;
wire ch_hit;
wire [2:0] reg_ofs;

assign ch_sel = reg_addr[5:3];
assign reg_ofs = reg_addr[2:0];
assign ch_hit = (reg_addr[7:5] == 3'h0);

// per-channel source select and request latch
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : gch
        // select code indexes any source line, timers and ext ints included
        assign src_now[g] = irq_src[sel[g]];
        assign rise[g] = src_now[g] & ~src_q[g];
    end
endgenerate

// lowest numbered pending channel wins
always @* begin
    pick = 2'h0;
    pick_ok = 1'b0;
    if (pend[3]) begin
        pick = 2'h3;
        pick_ok = 1'b1;
    end
    if (pend[2]) begin
        pick = 2'h2;
        pick_ok = 1'b1;
    end
    if (pend[1]) begin
        pick = 2'h1;
        pick_ok = 1'b1;
    end
    if (pend[0]) begin
        pick = 2'h0;
        pick_ok = 1'b1;
    end
end

integer i;
always @(posedge clk) begin
    if (!rst_b) begin
        for (i = 0; i < 4; i = i + 1) begin
            ctrl[i] <= 16'h0000;
            sel[i] <= 8'h00;
            sta[i] <= 24'h000000;
            stb[i] <= 24'h000000;
            pad[i] <= 16'h0000;
            cnt[i] <= 16'h0000;
            done_cnt[i] <= 16'h0000;
            cur[i] <= 24'h000000;
        end
        pp_b <= 4'h0;
        pend <= 4'h0;
        src_q <= 4'h0;
        state <= ST_IDLE;
        act <= 2'h0;
        data_q <= 16'h0000;
        last_sram_address <= `FDMA_RST_LAST;
        reg_rdata <= 16'h0000;
        sram_req <= 1'b0;
        sram_we <= 1'b0;
        sram_addr <= 24'h000000;
        sram_wdata <= 16'h0000;
        sram_byte <= 1'b0;
        peri_req <= 1'b0;
        peri_we <= 1'b0;
        peri_addr <= 16'h0000;
        peri_wdata <= 16'h0000;
        peri_byte <= 1'b0;
        ch_irq <= 4'h0;
    end else begin
        src_q <= src_now;
        ch_irq <= 4'h0;
        // request latching; a same-cycle set survives the service clear, except at one-shot block end
        for (i = 0; i < 4; i = i + 1) begin
            if (ctrl[i][`FDMA_CTL_EN] && (rise[i] || ctrl[i][`FDMA_CTL_FORCE])) begin
                pend[i] <= 1'b1;
            end
        end
        for (i = 0; i < 4; i = i + 1) begin
            if (ctrl[i][`FDMA_CTL_FORCE]) begin
                ctrl[i][`FDMA_CTL_FORCE] <= 1'b0;
            end
        end
        // register writes
        if (reg_wr && ch_hit) begin
            case (reg_ofs)
                `FDMA_OFS_CTRL: begin
                    ctrl[ch_sel[1:0]] <= reg_wdata;
                    if (reg_wdata[`FDMA_CTL_EN] && !ctrl[ch_sel[1:0]][`FDMA_CTL_EN]) begin
                        cur[ch_sel[1:0]] <= sta[ch_sel[1:0]];
                        done_cnt[ch_sel[1:0]] <= 16'h0000;
                        pp_b[ch_sel[1:0]] <= 1'b0;
                    end
                end
                `FDMA_OFS_SEL: sel[ch_sel[1:0]] <= reg_wdata[7:0];
                `FDMA_OFS_STA_LO: sta[ch_sel[1:0]][15:0] <= reg_wdata;
                `FDMA_OFS_STB_LO: stb[ch_sel[1:0]][15:0] <= reg_wdata;
                `FDMA_OFS_PAD: pad[ch_sel[1:0]] <= reg_wdata;
                `FDMA_OFS_CNT: cnt[ch_sel[1:0]] <= reg_wdata;
                `FDMA_OFS_STA_HI: sta[ch_sel[1:0]][23:16] <= reg_wdata[7:0];
                default: stb[ch_sel[1:0]][23:16] <= reg_wdata[7:0];
            endcase
        end
        // register reads, data next cycle
        reg_rdata <= 16'h0000;
        if (reg_rd) begin
            if (ch_hit) begin
                case (reg_ofs)
                    `FDMA_OFS_CTRL: reg_rdata <= ctrl[ch_sel[1:0]];
                    `FDMA_OFS_SEL: reg_rdata <= {8'h00, sel[ch_sel[1:0]]};
                    `FDMA_OFS_STA_LO: reg_rdata <= sta[ch_sel[1:0]][15:0];
                    `FDMA_OFS_STB_LO: reg_rdata <= stb[ch_sel[1:0]][15:0];
                    `FDMA_OFS_PAD: reg_rdata <= pad[ch_sel[1:0]];
                    `FDMA_OFS_CNT: reg_rdata <= cnt[ch_sel[1:0]];
                    `FDMA_OFS_STA_HI: reg_rdata <= {8'h00, sta[ch_sel[1:0]][23:16]};
                    default: reg_rdata <= {8'h00, stb[ch_sel[1:0]][23:16]};
                endcase
            end else if (reg_addr == `FDMA_REG_STAT) begin
                reg_rdata <= {8'h00, pp_b, pend};
            end else if (reg_addr == `FDMA_REG_LAST_LO) begin
                reg_rdata <= last_sram_address[15:0];
            end else if (reg_addr == `FDMA_REG_LAST_HI) begin
                reg_rdata <= {8'h00, last_sram_address[23:16]};
            end
        end
        // transfer engine: source read, then destination write
        case (state)
            ST_IDLE: begin
                if (pick_ok) begin
                    act <= pick;
                    state <= ST_SRC;
                    // peripheral-to-sram reads the peripheral first
                    if (!ctrl[pick][`FDMA_CTL_DIR]) begin
                        peri_req <= 1'b1;
                        peri_we <= 1'b0;
                        peri_addr <= pad[pick];
                        peri_byte <= ctrl[pick][`FDMA_CTL_SIZE];
                    end else begin
                        sram_req <= 1'b1;
                        sram_we <= 1'b0;
                        sram_byte <= ctrl[pick][`FDMA_CTL_SIZE];
                        if (ctrl[pick][`FDMA_CTL_AMODE_HI:`FDMA_CTL_AMODE_LO] == `FDMA_AM_PERI)
                            sram_addr <= {8'h00, peri_addr_in[pick*16 +: 16]};
                        else
                            sram_addr <= cur[pick];
                    end
                end
            end
            ST_SRC: begin
                if (peri_req && peri_ack) begin
                    data_q <= peri_rdata;
                    peri_req <= 1'b0;
                    sram_req <= 1'b1;
                    sram_we <= 1'b1;
                    sram_byte <= ctrl[act][`FDMA_CTL_SIZE];
                    sram_wdata <= peri_rdata;
                    if (ctrl[act][`FDMA_CTL_AMODE_HI:`FDMA_CTL_AMODE_LO] == `FDMA_AM_PERI)
                        sram_addr <= {8'h00, peri_addr_in[act*16 +: 16]};
                    else
                        sram_addr <= cur[act];
                    state <= ST_DST;
                end else if (sram_req && sram_gnt) begin
                    sram_req <= 1'b0;
                    last_sram_address <= sram_addr;
                    peri_req <= 1'b1;
                    peri_we <= 1'b1;
                    peri_addr <= pad[act];
                    peri_byte <= ctrl[act][`FDMA_CTL_SIZE];
                    peri_wdata <= sram_rdata;
                    state <= ST_DST;
                end
            end
            ST_DST: begin
                if (sram_req && sram_gnt) begin
                    sram_req <= 1'b0;
                    last_sram_address <= sram_addr;
                    state <= ST_END;
                end else if (peri_req && peri_ack) begin
                    peri_req <= 1'b0;
                    state <= ST_END;
                end
            end
            default: begin
                pend[act] <= rise[act] | ctrl[act][`FDMA_CTL_FORCE];
                state <= ST_IDLE;
                if (ctrl[act][`FDMA_CTL_AMODE_HI:`FDMA_CTL_AMODE_LO] == `FDMA_AM_INC) begin
                    cur[act] <= cur[act] + (ctrl[act][`FDMA_CTL_SIZE] ? 24'h000001 : 24'h000002);
                end
                if (ctrl[act][`FDMA_CTL_HALF] && (done_cnt[act] == {1'b0, cnt[act][15:1]})) begin
                    ch_irq[act] <= 1'b1;
                end
                if (done_cnt[act] == cnt[act]) begin
                    done_cnt[act] <= 16'h0000;
                    if (!ctrl[act][`FDMA_CTL_HALF]) begin
                        ch_irq[act] <= 1'b1;
                    end
                    if (ctrl[act][`FDMA_CTL_MODE_LO + `FDMA_BM_PINGPONG]) begin
                        pp_b[act] <= ~pp_b[act];
                        cur[act] <= pp_b[act] ? sta[act] : stb[act];
                    end else begin
                        cur[act] <= sta[act];
                    end
                    if (!ctrl[act][`FDMA_CTL_MODE_LO + `FDMA_BM_REPEAT]) begin
                        ctrl[act][`FDMA_CTL_EN] <= 1'b0;
                        pend[act] <= 1'b0;
                    end
                end else begin
                    done_cnt[act] <= done_cnt[act] + 16'h0001;
                end
            end
        endcase
    end
end
endmodule

// file: dv/fdma_top_monitor.sv
// fdma_top_monitor.sv: port-level checks of the dma controller
// assumes: bound to fdma_top, one clock, synchronous active-low reset
module fdma_mon (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire sram_req,
    input wire sram_gnt,
    input wire sram_we,
    input wire [23:0] sram_addr,
    input wire [15:0] sram_wdata,
    input wire peri_req,
    input wire peri_ack,
    input wire peri_we,
    input wire peri_byte,
    input wire [15:0] peri_addr,
    input wire [15:0] peri_rdata,
    input wire [3:0] ch_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    chk_sram_hold: assert property (sram_req && !sram_gnt |=> sram_req && $stable(sram_addr)
        && $stable(sram_we)) else $error("sram request dropped or moved");
    chk_peri_hold: assert property (peri_req && !peri_ack |=> peri_req && $stable(peri_addr))
        else $error("peripheral request dropped or moved");
    chk_dir_pair: assert property (peri_req && peri_ack && !peri_we |=> sram_req && sram_we)
        else $error("peripheral read not followed by sram write");
    chk_data_pass: assert property (peri_req && peri_ack && !peri_we && !peri_byte
        |=> sram_wdata == $past(peri_rdata)) else $error("word not passed to sram");
    chk_irq_single: assert property ($onehot0(ch_irq))
        else $error("two channels done at once");
    chk_irq_pulse: assert property (|ch_irq |=> ch_irq == 4'h0)
        else $error("interrupt longer than one cycle");
    chk_irq_cause: assert property (|ch_irq |-> $past(sram_req && sram_gnt, 2)
        || $past(peri_req && peri_ack, 2)) else $error("interrupt without transfer");
    chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    chk_hi_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h22
        |-> reg_rdata[15:8] == 8'h00) else $error("high address upper byte not zero");
endmodule
bind fdma_top fdma_mon u_mon (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sram_req(sram_req), .sram_gnt(sram_gnt), .sram_we(sram_we),
    .sram_addr(sram_addr), .sram_wdata(sram_wdata), .peri_req(peri_req), .peri_ack(peri_ack),
    .peri_we(peri_we), .peri_byte(peri_byte), .peri_addr(peri_addr), .peri_rdata(peri_rdata),
    .ch_irq(ch_irq));

// file: dv/fdma_far.sv
// fdma_far.sv: peripherals and sram arbiter seen from the dma controller
// assumes: same clock as the controller; slow makes the cpu hold memory
module fdma_far (
    input wire clk,
    input wire rst_b,
    input wire slow,
    input wire sram_req,
    input wire [23:0] sram_addr,
    output reg sram_gnt,
    output reg [15:0] sram_rdata,
    input wire peri_req,
    input wire [15:0] peri_addr,
    output reg peri_ack,
    output reg [15:0] peri_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [1:0] hold;
    // with slow set, cpu owns memory for a while before the dma gets it
    always @(posedge clk) begin
        hold <= (!rst_b || !sram_req) ? 2'h0 : hold + {1'b0, hold != 2'h3};
        sram_gnt <= rst_b && sram_req && !sram_gnt && (!slow || hold == 2'h2);
        sram_rdata <= (sram_req && !sram_gnt) ? sram_addr[15:0] ^ 16'hC3C3 : ~sram_rdata;
        // answer each peripheral cycle once; data is junk outside it
        peri_ack <= rst_b && peri_req && !peri_ack;
        peri_rdata <= (peri_req && !peri_ack) ? peri_addr ^ 16'h5A5A : ~peri_rdata;
    end
endmodule

// file: dv/fdma_top_tb.sv
// fdma_top_tb.sv: self-checking bench of the dma controller
// assumes: fdma_far answers sram and peripheral cycles
module fdma_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [255:0] irq_src = 256'h0;
    reg [63:0] peri_addr_in = 64'h0;
    reg slow = 1'b0;
    wire [15:0] reg_rdata, sram_rdata, sram_wdata, peri_addr, peri_wdata, peri_rdata;
    wire [23:0] sram_addr;
    wire sram_req, sram_gnt, sram_we, sram_byte, peri_req, peri_ack, peri_we, peri_byte;
    wire [3:0] ch_irq;
    integer err_total = 0;
    integer checked = 0;
    integer cycles = 0;
    integer irq_tot = 0;
    integer i, n0;
    reg [3:0] irq_ch = 4'h0;
    reg [23:0] seen [$];
    reg [15:0] dat = 16'h0000;
    reg [15:0] paddr = 16'h0000;
    reg swe = 1'b0;
    reg sbyte = 1'b0;
    reg pbyte = 1'b0;
    // {code, dir, byte, peripheral address}
    reg [25:0] rows [0:6] = '{{8'h00, 2'b00, 16'h0300},
        {8'h07, 2'b11, 16'h0310}, {8'h0B, 2'b00, 16'h0226},
        {8'h0C, 2'b10, 16'h0224}, {8'h01, 2'b00, 16'h0144},
        {8'h02, 2'b10, 16'h0906}, {8'h02, 2'b10, 16'h0904}};
    fdma_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_src(irq_src),
        .peri_addr_in(peri_addr_in), .sram_req(sram_req), .sram_gnt(sram_gnt), .sram_we(sram_we),
        .sram_addr(sram_addr), .sram_wdata(sram_wdata), .sram_byte(sram_byte),
        .sram_rdata(sram_rdata), .peri_req(peri_req), .peri_ack(peri_ack), .peri_we(peri_we),
        .peri_addr(peri_addr), .peri_wdata(peri_wdata), .peri_byte(peri_byte),
        .peri_rdata(peri_rdata), .ch_irq(ch_irq));
    fdma_far u_far (.clk(clk), .rst_b(rst_b), .slow(slow), .sram_req(sram_req),
        .sram_addr(sram_addr), .sram_gnt(sram_gnt), .sram_rdata(sram_rdata),
        .peri_req(peri_req), .peri_addr(peri_addr), .peri_ack(peri_ack), .peri_rdata(peri_rdata));
    always #50 clk = ~clk;
    task test_done;
        begin
            $display("compares %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            test_done;
        end
        if (sram_req && sram_gnt) seen.push_back(sram_addr);
        if (sram_req && sram_gnt && sram_we) dat <= sram_wdata;
        if (sram_req && sram_gnt) swe <= sram_we;
        if (sram_req && sram_gnt) sbyte <= sram_byte;
        if (peri_req && peri_ack) paddr <= peri_addr;
        if (peri_req && peri_ack) pbyte <= peri_byte;
        if (peri_req && peri_ack && peri_we) dat <= peri_wdata;
        if (|ch_irq) irq_tot <= irq_tot + 1;
        if (|ch_irq) irq_ch <= ch_irq;
    end
    task cmp(input [23:0] got, input [23:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("FAIL t=%0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [15:0] exp);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 cmp({8'h00, reg_rdata}, {8'h00, exp});
        end
    endtask
    task cfg(input [7:0] b, input [8:0] ctl, input [7:0] sel, input [23:0] a, input [23:0] bb,
        input [15:0] cnt);
        begin
            wr(b, 16'h0000);
            wr(b + 8'h01, {8'h00, sel});
            wr(b + 8'h02, a[15:0]);
            wr(b + 8'h06, {8'h00, a[23:16]});
            wr(b + 8'h03, bb[15:0]);
            wr(b + 8'h07, {8'h00, bb[23:16]});
            wr(b + 8'h05, cnt);
            wr(b, {7'h00, ctl});
            seen.delete();
            n0 = irq_tot;
        end
    endtask
    task wt(input integer n);
        integer w;
        begin
            w = 0;
            while (seen.size() < n && w < 80) begin
                @(posedge clk);
                w = w + 1;
            end
            cmp(w < 80, 1'b1);
            repeat (6) @(posedge clk);
        end
    endtask
    task go(input [7:0] code, input integer n);
        begin
            @(posedge clk);
            irq_src[code] <= 1'b1;
            @(posedge clk);
            irq_src[code] <= 1'b0;
            wt(n);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        wr(8'h21, 16'hFFFF);
        rd(8'h21, 16'h0000);
        rd(8'h22, 16'h0000);
        rd(8'h23, 16'h0000);
        $display("test reset done");
        for (i = 0; i < 7; i = i + 1) begin
            cfg(8'h08, {6'h00, rows[i][17:16], 1'b1}, rows[i][25:18], 24'h000100 + i * 16, 0, 0);
            wr(8'h0C, rows[i][15:0]);
            go(rows[i][25:18], 1);
            cmp(paddr, rows[i][15:0]);
            cmp(swe, !rows[i][17]);
            cmp(sbyte, rows[i][16]);
            cmp(pbyte, rows[i][16]);
            cmp(irq_ch, 4'h2);
            if (!rows[i][16]) cmp(dat, rows[i][17] ? (16'h0100 + i * 16) ^ 16'hC3C3
                : rows[i][15:0] ^ 16'h5A5A);
            rd(8'h21, 16'h0100 + i * 16);
        end
        $display("test table done");
        for (i = 0; i < 4; i = i + 1) cfg(i * 8, 9'h001, 8'h07, 24'h001000 * (i + 1), 0, 0);
        go(8'h07, 4);
        for (i = 0; i < 4; i = i + 1) cmp(seen[i], 24'h001000 * (i + 1));
        cmp(irq_tot - n0, 4);
        $display("test priority done");
        cfg(8'h18, 9'h009, 8'h0B, 24'h002000, 0, 3);
        for (i = 0; i < 5; i = i + 1) begin
            go(8'h0B, i < 4 ? i + 1 : 4);
            cmp(irq_tot - n0, i > 0);
        end
        for (i = 0; i < 4; i = i + 1) cmp(seen[i], 24'h002000 + 2 * i);
        cmp(seen.size(), 4);
        $display("test increment done");
        slow <= 1'b1;
        cfg(8'h10, 9'h013, 8'h0C, 24'h003001, 0, 1);
        go(8'h0C, 1);
        cmp(irq_tot - n0, 0);
        go(8'h0C, 2);
        cmp({seen[0], seen[1]}, {24'h003001, 24'h003001});
        cmp(irq_tot - n0, 1);
        slow <= 1'b0;
        cfg(8'h00, 9'h0C1, 8'h00, 24'h123400, 24'h005600, 0);
        go(8'h00, 1);
        go(8'h00, 2);
        wr(8'h00, 16'h01C1);
        wt(3);
        cmp(seen[0], 24'h123400);
        cmp(seen[1], 24'h005600);
        cmp(seen[2], 24'h123400);
        rd(8'h22, 16'h0012);
        $display("test ping-pong done");
        peri_addr_in <= 64'h2468;
        cfg(8'h00, 9'h021, 8'h01, 24'h004000, 0, 0);
        go(8'h01, 1);
        cmp(seen[0][15:0], 16'h2468);
        $display("test indirect done");
        test_done;
    end
endmodule
